// file: hdl/pfes_status.sv
// sticky fault and event status register with processor-hot control
`timescale 1ns/1ps
`include "pfes_params.svh"
module pfes_status
    import pfes_pkg::*;
(
    input  wire logic        clk_sys,        // 200 MHz system clock
    input  wire logic        reset,          // synchronous, active high
    input  wire pfes_req_t   req,            // register access request
    input  wire pfes_cond_t  cond,           // live fault conditions
    input  wire pfes_ctrl_t  ctrl,           // disables and enables
    input  wire logic        dischgStart,    // one-cycle discharge start
    output logic [15:0]      rdData,         // read data, registered
    output logic [15:0]      statusOut,      // status register value
    output logic             alertReq,       // masked event summary
    output logic             processorHotO,  // processor_hot_n output level
    output logic             processorHotOeN // low while pin is driven
);
    logic [15:0] status_ff;
    logic [15:0] mask_ff;
    logic [15:0] nxt_status;
    logic        faultPrev_ff;
    logic [31:0] dischgCnt_ff;
    pfes_dstate_t dstate_ff;
    logic        dTimeout;
    logic        dDone;
    logic [15:0] openCnt_ff;
    logic        openHit;
    logic [15:0] w1c;

    // timeout selection, reused for compare
    function automatic logic [31:0] to_cycles(input logic [1:0] sel);
        logic [31:0] ms;
        ms = 32'h0;
        case (sel)
            2'h0: ms = 32'(`PFES_TO_MS_0);
            2'h1: ms = 32'(`PFES_TO_MS_1);
            2'h2: ms = 32'(`PFES_TO_MS_2);
            default: ms = 32'(`PFES_TO_MS_3);
        endcase
        to_cycles = ms * 32'(`PFES_CYC_PER_MS);
    endfunction : to_cycles

    assign w1c = (req.wrEn && req.addr == `PFES_STATUS_OFFSET) ? req.wdata : 16'h0000;

    // sink discharge engine timer; a start while running is ignored
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dstate_ff    <= DS_IDLE;
            dischgCnt_ff <= 32'h0;
        end else begin
            case (dstate_ff)
                DS_IDLE: begin
                    dischgCnt_ff <= 32'h0;
                    if (dischgStart) begin
                        dstate_ff <= DS_RUN;
                    end
                end
                DS_RUN: begin
                    dischgCnt_ff <= dischgCnt_ff + 32'h1;
                    if (dTimeout || cond.sinkSafe) begin
                        dstate_ff <= DS_IDLE;
                    end
                end
                default: dstate_ff <= DS_IDLE;
            endcase
        end
    end
    assign dTimeout = (dstate_ff == DS_RUN) && !cond.sinkSafe &&
                      (dischgCnt_ff >= to_cycles(ctrl.dischgTimeout) - 32'h1);     // [R1]
    assign dDone    = (dstate_ff == DS_RUN) && (cond.sinkSafe || dTimeout);        // [R2]

    // open condition must hold continuously beyond the window
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            openCnt_ff <= 16'h0;
        end else if (!cond.sinkOpen) begin
            openCnt_ff <= 16'h0;
        end else if (!openHit) begin
            openCnt_ff <= openCnt_ff + 16'h1;
        end
    end
    assign openHit = (openCnt_ff > 16'(`PFES_OPEN_CYCLES));                         // [R13]

    // flag update: except for bit 1, set wins over clear, clear only once the source has gone
    always_comb begin
        nxt_status = status_ff & ~w1c;                                              // [R18]
        if (ctrl.otpDis) nxt_status[`PFES_BIT_OTP] = 1'b0;
        if (ctrl.rvpDis) nxt_status[`PFES_BIT_RVP] = 1'b0;
        if (ctrl.uvpDis) nxt_status[`PFES_BIT_UVP] = 1'b0;
        if (ctrl.ovpDis) nxt_status[`PFES_BIT_OVP] = 1'b0;
        if (ctrl.srcRvpDis) nxt_status[`PFES_BIT_SRVP] = 1'b0;
        if (ctrl.srcUvpDis) nxt_status[`PFES_BIT_SUVP] = 1'b0;
        if (dTimeout) nxt_status[`PFES_BIT_DTIMEOUT] = 1'b1;                        // [R1]
        if (dDone) nxt_status[`PFES_BIT_DDONE] = 1'b1;                              // [R2]
        if (cond.otp && !ctrl.otpDis) nxt_status[`PFES_BIT_OTP] = 1'b1;             // [R3]
        if (cond.rvp && !ctrl.rvpDis) nxt_status[`PFES_BIT_RVP] = 1'b1;             // [R4]
        if (cond.uvp && !ctrl.uvpDis) nxt_status[`PFES_BIT_UVP] = 1'b1;             // [R5]
        if (cond.ovp && !ctrl.ovpDis) nxt_status[`PFES_BIT_OVP] = 1'b1;             // [R6]
        if (cond.vconnLow) nxt_status[`PFES_BIT_VC08] = 1'b1;                       // [R7]
        if (cond.faultState != faultPrev_ff) nxt_status[`PFES_BIT_FCHG] = 1'b1;     // [R10]
        if (cond.srcRvp && !ctrl.srcRvpDis) nxt_status[`PFES_BIT_SRVP] = 1'b1;      // [R11]
        if (cond.srcUvp && !ctrl.srcUvpDis) nxt_status[`PFES_BIT_SUVP] = 1'b1;      // [R12]
        if (openHit && !status_ff[`PFES_BIT_DHOT] && openCnt_ff == 16'(`PFES_OPEN_CYCLES) + 16'h1)
            nxt_status[`PFES_BIT_DHOT] = 1'b1;                                      // [R13]
        // companion bit follows detach so the host clears both together
        if (openHit && openCnt_ff == 16'(`PFES_OPEN_CYCLES) + 16'h1)
            nxt_status[`PFES_BIT_DCOMP] = 1'b1;                                     // [R15]
        nxt_status[`PFES_BIT_FSTATE] = cond.faultState;                             // [R9]
        nxt_status = nxt_status & ~`PFES_RESERVED_MASK;                             // [R8]
    end

    // status and fault history
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_ff    <= `PFES_STATUS_RESET;
            faultPrev_ff <= 1'b0;
        end else begin
            status_ff    <= nxt_status;                                             // [R14]
            faultPrev_ff <= cond.faultState;
        end
    end

    // mask register; reserved and status-only positions stay zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mask_ff <= 16'h0000;
        end else if (req.wrEn && req.addr == `PFES_MASK_OFFSET) begin
            mask_ff <= req.wdata & ~(`PFES_RESERVED_MASK | 16'h0021);
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdData          <= 16'h0000;
            statusOut       <= 16'h0000;
            alertReq        <= 1'b0;
            processorHotO   <= 1'b1;
            processorHotOeN <= 1'b1;
        end else begin
            if (req.rdEn && req.addr == `PFES_STATUS_OFFSET) rdData <= status_ff;   // [R8]
            else if (req.rdEn && req.addr == `PFES_MASK_OFFSET) rdData <= mask_ff;
            else if (req.rdEn) rdData <= 16'h0000;
            statusOut     <= nxt_status;
            alertReq      <= |(nxt_status & mask_ff);                               // [R17]
            processorHotO <= 1'b0;
            // driven low only while detach is armed, released otherwise
            processorHotOeN <= !((ctrl.detachDebounce != 4'h0) && ctrl.detachEn &&
                                 nxt_status[`PFES_BIT_DHOT]);                       // [R16]
            if (!nxt_status[`PFES_BIT_DHOT] && !ctrl.altExt0)
                processorHotOeN <= 1'b1;                                            // [R14]
        end
    end
endmodule : pfes_status

// file: hdl/pfes_params.svh
// constants for the port fault event status block
// Notes on behaviour
// [R1] bit 15 set when sink discharge times out
// [R2] bit 14 set when sink discharge ends
// [R3] bit 13 VCONN over-temperature, sticky while present
// [R4] bit 12 VCONN reverse voltage, sticky while present
// [R5] bit 11 VCONN under-voltage, sticky while present
// [R6] bit 10 VCONN over-voltage, sticky while present
// [R7] bit 9 VCONN below 0.8V, regardless of enable
// [R8] reserved bits 8:7 and 2 read zero
// [R9] bit 5 mirrors fault state, read only
// [R10] bit 6 set on fault state change
// [R11] bit 4 source reverse voltage, sticky while present
// [R12] bit 3 source under-voltage, sticky while present
// [R13] bit 1 set after CC open over 40us
// [R14] write one clears bit 1; release processor-hot
// [R15] host clears bit 0 with any other flag
// [R16] processor-hot needs debounce, enable and bit 1
// [R17] events alert only when mask bit set
// [R18] zero writes keep; clear needs source gone (bit 1 clears on a one write even while open holds)
`ifndef PFES_PARAMS_SVH
`define PFES_PARAMS_SVH
`define PFES_STATUS_OFFSET   8'ha0
`define PFES_MASK_OFFSET     8'ha2
`define PFES_STATUS_RESET    16'h0000
`define PFES_RESERVED_MASK   16'h0184
`define PFES_BIT_DTIMEOUT    15
`define PFES_BIT_DDONE       14
`define PFES_BIT_OTP         13
`define PFES_BIT_RVP         12
`define PFES_BIT_UVP         11
`define PFES_BIT_OVP         10
`define PFES_BIT_VC08        9
`define PFES_BIT_FCHG        6
`define PFES_BIT_FSTATE      5
`define PFES_BIT_SRVP        4
`define PFES_BIT_SUVP        3
`define PFES_BIT_DHOT        1
`define PFES_BIT_DCOMP       0
`define PFES_CLK_MHZ         200
`define PFES_OPEN_TIME_NS    40000
`define PFES_OPEN_CYCLES     ((`PFES_OPEN_TIME_NS * `PFES_CLK_MHZ + 999) / 1000)
`define PFES_TO_MS_0         150
`define PFES_TO_MS_1         200
`define PFES_TO_MS_2         250
`define PFES_TO_MS_3         300
`define PFES_CYC_PER_MS      (`PFES_CLK_MHZ * 1000)
`endif

// file: hdl/pfes_pkg.sv
// types for the port fault event status block
package pfes_pkg;
    // register port request
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [15:0] wdata;
    } pfes_req_t;
    // analog and engine condition inputs
    typedef struct packed {
        logic otp;
        logic rvp;
        logic uvp;
        logic ovp;
        logic vconnLow;
        logic srcRvp;
        logic srcUvp;
        logic faultState;
        logic sinkOpen;
        logic sinkSafe;
    } pfes_cond_t;
    // disable and enable controls
    typedef struct packed {
        logic       otpDis;
        logic       rvpDis;
        logic       uvpDis;
        logic       ovpDis;
        logic       srcRvpDis;
        logic       srcUvpDis;
        logic [1:0] dischgTimeout;
        logic [3:0] detachDebounce;
        logic       detachEn;
        logic       altExt0;
    } pfes_ctrl_t;
    typedef enum logic [1:0] {DS_IDLE, DS_RUN} pfes_dstate_t;
endpackage : pfes_pkg

// file: tb/pfes_host.sv
// port manager model issuing register accesses
`timescale 1ns/1ps
module pfes_host
    import pfes_pkg::*;
(
    input  wire logic clk_sys, // system clock
    output pfes_req_t req      // register request
);
    initial req = '0;
    // one-cycle strobe; bit 0 goes with any other flag cleared
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        req <= '{w, !w, a, d | {15'h0, w && a == 8'ha0 && |(d & 16'hfe5a)}};
        @(posedge clk_sys);
        req <= '0;
        #1;
    endtask : acc
endmodule : pfes_host

// file: tb/pfes_status_assertions.sv
// port checks for the fault event status block
`timescale 1ns/1ps
module pfes_status_assertions
    import pfes_pkg::*;
(
    input wire logic        clk_sys,         // clock
    input wire logic        reset,           // reset
    input wire pfes_req_t   req,             // request
    input wire pfes_cond_t  cond,            // conditions
    input wire pfes_ctrl_t  ctrl,            // controls
    input wire logic        dischgStart,     // discharge start
    input wire logic [15:0] rdData,          // read data
    input wire logic [15:0] statusOut,       // status
    input wire logic        alertReq,        // alert
    input wire logic        processorHotO,   // pin level
    input wire logic        processorHotOeN  // pin enable
);
    logic [15:0] openCnt;
    logic [15:0] wrOnes;
    logic [15:0] disBits;
    // open run length, saturating so a long open never wraps
    always_ff @(posedge clk_sys) begin
        openCnt <= (reset || !cond.sinkOpen) ? 16'h0 : openCnt + {15'h0, ~&openCnt};
    end
    assign wrOnes = (req.wrEn && req.addr == 8'ha0) ? req.wdata : 16'h0;
    // a disabled detector may drop its flag without a write
    assign disBits = {2'h0, ctrl.otpDis, ctrl.rvpDis, ctrl.uvpDis, ctrl.ovpDis, 5'h0,
                      ctrl.srcRvpDis, ctrl.srcUvpDis, 3'h0};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_fsHigh;
        cond.faultState [*3];
    endsequence
    sequence s_hotIdle;
        (!statusOut[1] && !ctrl.altExt0) [*3];
    endsequence
    chk_reserved_zero: assert property ((statusOut & 16'h0184) == 16'h0)
        else $error("reserved bit set");
    chk_fstate_mirror: assert property (s_fsHigh |-> statusOut[5])
        else $error("fault state not shown");
    chk_w1c_keep: assert property ((($past(statusOut) & ~$past(wrOnes) & ~$past(disBits) & 16'hfe5b) & ~statusOut) == 16'h0)
        else $error("flag fell unwritten");
    chk_otp_sticky: assert property (statusOut[13] && cond.otp && !ctrl.otpDis |=> statusOut[13])
        else $error("flag cleared while present");
    chk_hot_release: assert property (s_hotIdle |-> processorHotOeN)
        else $error("pin not released");
    chk_hot_cause: assert property ($fell(processorHotOeN) |-> $past(ctrl.detachEn) && statusOut[1] && $past(ctrl.detachDebounce) != 4'h0)
        else $error("pin driven without cause");
    chk_open_debounce: assert property ($rose(statusOut[1]) |-> $past(openCnt, 2) >= 16'd7990)
        else $error("detach too early");
    chk_done_safe: assert property (dischgStart && cond.sinkSafe |-> ##[1:4] statusOut[14])
        else $error("discharge end missed");
    chk_fault_change: assert property ($changed(cond.faultState) |-> ##[1:3] statusOut[6])
        else $error("change not flagged");
endmodule : pfes_status_assertions
bind pfes_status pfes_status_assertions u_chk (.clk_sys(clk_sys), .reset(reset), .req(req),
    .cond(cond), .ctrl(ctrl), .dischgStart(dischgStart), .rdData(rdData), .statusOut(statusOut),
    .alertReq(alertReq), .processorHotO(processorHotO), .processorHotOeN(processorHotOeN));

// file: tb/pfes_status_tb.sv
// self-checking bench for the fault event status block
`timescale 1ns/1ps
module pfes_status_tb;
    import pfes_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        dischgStart = 1'b0;
    logic [9:0]  condV = 10'h0;
    logic [13:0] ctrlV = 14'h0;
    logic [15:0] rdData, statusOut;
    logic        alertReq, hotO, hotOeN;
    pfes_req_t   req;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    always #2.5 clk_sys = ~clk_sys;
    pfes_host u_host (.clk_sys(clk_sys), .req(req));
    pfes_status u_dut (.clk_sys(clk_sys), .reset(reset), .req(req), .cond(pfes_cond_t'(condV)),
        .ctrl(pfes_ctrl_t'(ctrlV)), .dischgStart(dischgStart), .rdData(rdData),
        .statusOut(statusOut), .alertReq(alertReq), .processorHotO(hotO), .processorHotOeN(hotOeN));
    task automatic cy(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cy
    task automatic drv(input logic [9:0] c, input logic [13:0] k);
        @(posedge clk_sys);
        condV <= c;
        ctrlV <= k;
    endtask : drv
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic conclude();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    // each event: ignored when disabled except bit 9, sticky while present, cleared by one
    task automatic t_events();
        int cb[7] = '{9, 8, 7, 6, 5, 4, 3};
        int sb[7] = '{13, 12, 11, 10, 9, 4, 3};
        int db[7] = '{13, 12, 11, 10, 0, 9, 8};
        for (int i = 0; i < 7; i++) begin
            drv(10'h1 << cb[i], 14'h1 << db[i]);
            cy(4);
            chk(statusOut >> sb[i] & 16'h1, 16'(i == 4), "disable");
            drv(10'h1 << cb[i], 14'h0);
            cy(4);
            chk(statusOut >> sb[i] & 16'h1, 16'h1, "set");
            u_host.acc(1'b0, 8'ha0, 16'h0);
            chk(rdData, 16'h1 << sb[i], "read back");
            u_host.acc(1'b1, 8'ha0, 16'h1 << sb[i]);
            chk(statusOut >> sb[i] & 16'h1, 16'h1, "present");
            drv(10'h0, 14'h0);
            u_host.acc(1'b1, 8'ha0, 16'h0);
            chk(statusOut, 16'h1 << sb[i], "zero write");
            u_host.acc(1'b1, 8'ha0, 16'h1 << sb[i]);
            chk(statusOut, 16'h0, "one write");
        end
    endtask : t_events
    task automatic t_misc();
        u_host.acc(1'b1, 8'ha0, 16'hffff);
        u_host.acc(1'b0, 8'ha0, 16'h0);
        chk(rdData, 16'h0, "reserved");
        drv(10'h200, 14'h0);
        cy(4);
        chk({15'h0, alertReq}, 16'h0, "masked");
        u_host.acc(1'b1, 8'ha2, 16'h2000);
        cy(2);
        chk({15'h0, alertReq}, 16'h1, "unmasked");
        u_host.acc(1'b0, 8'ha2, 16'h0);
        chk(rdData, 16'h2000, "mask read");
        drv(10'h4, 14'h0);
        u_host.acc(1'b1, 8'ha2, 16'h0);
        u_host.acc(1'b1, 8'ha0, 16'h2060);
        chk(statusOut & 16'h60, 16'h20, "state write");
        drv(10'h1, 14'h0);
        cy(4);
        chk(statusOut & 16'h60, 16'h40, "state change");
        @(posedge clk_sys);
        dischgStart <= 1'b1;
        @(posedge clk_sys);
        dischgStart <= 1'b0;
        cy(4);
        chk(statusOut & 16'hc000, 16'h4000, "discharge");
    endtask : t_misc
    // detach: short open ignored, long open flags, pin follows enable
    task automatic t_detach();
        drv(10'h2, 14'h4);
        cy(7000);
        drv(10'h0, 14'h4);
        cy(2);
        chk(statusOut & 16'h2, 16'h0, "short open");
        drv(10'h2, 14'h4);
        cy(8100);
        chk({14'h0, statusOut[1], hotOeN}, 16'h3, "detach");
        drv(10'h0, 14'h6);
        cy(3);
        chk({14'h0, hotO, hotOeN}, 16'h0, "pin driven");
        u_host.acc(1'b1, 8'ha0, 16'h0002);
        cy(3);
        chk({13'h0, statusOut[1:0], hotOeN}, 16'h1, "release");
    endtask : t_detach
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            $display("mismatch at %0t: timeout", $time);
            conclude();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        cy(1);
        chk(statusOut, 16'h0, "reset value");
        t_events();
        t_misc();
        t_detach();
        conclude();
    end
endmodule : pfes_status_tb
